// ==== verilog/monitor_pin_control.v ====
// Pin-level control of the hardware monitor: straps, open-drain pins, interrupt, registers
//
// Behaviour
// R1: Address bit 0 from low strap, bit 1 from high strap.
// R2: In tree test, low strap pin drives the tree result out.
// R3: Tree-select high enters tree test; otherwise pin is the fan output.
// R4: Serial data is open drain: release for one, receive on same line.
// R5: Config bit 6 pulls intrusion line low at least 20 ms.
// R6: Interrupt active low, enabled only by config bit 1, disabled after reset.
// R7: Config bit 4 drives open-drain reset low at least 20 ms.
// R8: External low on reset pin, debounced, restores power-up state; the code leaves interrupt status bit 2 set.
// R9: Interrupt can fire on any out-of-spec monitored quantity.
// R10: Voltage-id inputs readable through two id registers.
// R11: 8-bit fan converter code sets fan control output.
// R12: Serial address 01011 plus straps; host changes only upper bits.
// R13: Writing one to clear-register bit 7 clears intrusion event.
// R14: Id register bits 0-3 show pins 0-3; second shows pin 4 bit 0.
// R15: Pulse widths timed by an internal clock counter.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`include "monitor_pin_defines.vh"
`default_nettype none

module monitor_pin_control #(
  parameter integer PULSE_CYCLES = `PULSE_CYCLES,
  parameter integer DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter integer OOS_W = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata_q,
  // Address straps and tree test
  input wire addr_strap_low_tree_out_i,
  output reg addr_strap_low_tree_out_o,
  output reg addr_strap_low_tree_out_oe,
  input wire addr_strap_high,
  input wire fan_dac_out_tree_select,
  input wire [7:0] tree_inputs,
  output reg [7:0] fan_dac_code_q,
  output reg fan_dac_en_q,
  output reg [6:0] slave_addr_q,
  // Serial data, open drain
  input wire sda_i,
  input wire sda_tx,
  output reg sda_o,
  output reg sda_oe,
  output reg sda_rx_q,
  // Intrusion line, open drain
  input wire intrusion_line_i,
  output reg intrusion_line_o,
  output reg intrusion_line_oe,
  // System reset, open drain
  input wire sys_rst_b_i,
  output reg sys_rst_b_o,
  output reg sys_rst_b_oe,
  // Monitor events and identification
  input wire [OOS_W-1:0] oos_events,
  input wire [4:0] cpu_voltage_id_inputs,
  // Interrupt
  output reg int_b_q
);
  // ---------------------------------------------------------------
  // Soft reset from the reset pin
  // ---------------------------------------------------------------
  // Debounce needs a steady low for the whole window before acting
  reg [19:0] deb_cnt_q;
  reg soft_rst_q;
  wire rst_pin_low;
  wire rst_self;
  wire rst_pulse_busy;
  wire clr_pulse_busy;

  // Ignore our own drive so a generated pulse does not reset us
  assign rst_self = rst_pulse_busy || sys_rst_b_oe;
  assign rst_pin_low = !sys_rst_b_i && !rst_self;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      deb_cnt_q <= 20'h00000;
      soft_rst_q <= 1'b0;
    end else if (!rst_pin_low) begin
      deb_cnt_q <= 20'h00000;
      soft_rst_q <= 1'b0;
    end else if (deb_cnt_q == DEBOUNCE_CYCLES[19:0]) begin
      soft_rst_q <= 1'b1; // [R8]
    end else begin
      deb_cnt_q <= deb_cnt_q + 20'h00001;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [7:0] config_q;
  reg [7:0] status_q;
  reg [7:0] mask_q;
  reg [4:0] addr_high_q;
  reg [OOS_W-1:0] oos_seen_q;
  reg intr_seen_q;
  reg ext_rst_seen_q;
  reg [7:0] status_d;
  reg [7:0] set_vec;
  reg [7:0] clr_vec;
  wire wr_cfg;
  wire wr_clr;

  assign wr_cfg = wr_stb && (addr == `REG_CONFIG);
  assign wr_clr = wr_stb && (addr == `REG_INTR_CLEAR) && wdata[`INTR_CLEAR_BIT];

  // Event sources, edge detected so a held level sets once per onset
  reg intr_prev_q;
  reg oos_any_prev_q;
  wire oos_any;
  assign oos_any = |oos_events;

  // Raw levels padded to a byte; a zero-width pad is illegal when OOS_W is 8
  wire [7:0] oos_byte;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_oos
      if (gi < OOS_W) begin : g_used
        assign oos_byte[gi] = oos_events[gi];
      end else begin : g_pad
        assign oos_byte[gi] = 1'b0;
      end
    end
  endgenerate

  always @* begin
    set_vec = 8'h00;
    set_vec[`ST_OOS_BIT] = oos_any && !oos_any_prev_q; // [R9]
    set_vec[`ST_INTRUSION_BIT] = intrusion_line_i && !intr_prev_q && !clr_pulse_busy;
    set_vec[`ST_EXT_RST_BIT] = soft_rst_q;
    clr_vec = 8'h00;
    if (wr_stb && (addr == `REG_INT_STATUS)) begin
      clr_vec = wdata;
    end
    if (wr_clr) begin
      clr_vec[`ST_INTRUSION_BIT] = 1'b1; // [R13]
    end
    // Set wins over a simultaneous clear
    status_d = (status_q & ~clr_vec) | set_vec;
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_q <= `CONFIG_RESET;
      status_q <= 8'h00;
      mask_q <= 8'h00;
      addr_high_q <= `SER_ADDR_HIGH_RESET;
      fan_dac_code_q <= `FAN_DAC_RESET;
      intr_prev_q <= 1'b0;
      oos_any_prev_q <= 1'b0;
    end else if (soft_rst_q) begin
      config_q <= `CONFIG_RESET; // [R8]
      status_q <= 8'h00 | set_vec;
      mask_q <= 8'h00;
      addr_high_q <= `SER_ADDR_HIGH_RESET;
      fan_dac_code_q <= `FAN_DAC_RESET;
      intr_prev_q <= intrusion_line_i;
      oos_any_prev_q <= oos_any;
    end else begin
      intr_prev_q <= intrusion_line_i;
      oos_any_prev_q <= oos_any;
      status_q <= status_d;
      if (wr_cfg) begin
        config_q <= wdata;
      end else begin
        // Pulse-request bits self-clear once the pulse is running
        if (rst_pulse_busy) config_q[`CFG_RST_PULSE_BIT] <= 1'b0;
        if (clr_pulse_busy) config_q[`CFG_INTR_CLR_BIT] <= 1'b0;
      end
      if (wr_stb && (addr == `REG_INT_MASK)) mask_q <= wdata;
      if (wr_stb && (addr == `REG_SER_ADDR)) addr_high_q <= wdata[6:2]; // [R12]
      if (wr_stb && (addr == `REG_FAN_DAC)) fan_dac_code_q <= wdata; // [R11]
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `REG_CONFIG: rdata_q <= config_q;
        `REG_INT_STATUS: rdata_q <= status_q;
        `REG_INT_MASK: rdata_q <= mask_q;
        `REG_INTR_CLEAR: rdata_q <= 8'h00;
        `REG_VID: rdata_q <= {`VID_UPPER_RESET, cpu_voltage_id_inputs[3:0]}; // [R10] [R14]
        `REG_VID_FIFTH: rdata_q <= {`VID_FIFTH_UPPER, cpu_voltage_id_inputs[4]}; // [R14]
        `REG_SER_ADDR: rdata_q <= {1'b0, slave_addr_q};
        `REG_FAN_DAC: rdata_q <= fan_dac_code_q;
        `REG_OOS_EVENTS: rdata_q <= oos_byte;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Open-drain pulse timers
  // ---------------------------------------------------------------
  pulse_timer #(.CYCLES(PULSE_CYCLES), .W(20)) u_rst_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(config_q[`CFG_RST_PULSE_BIT]),
    .busy_q(rst_pulse_busy)
  ); // [R7] [R15]

  pulse_timer #(.CYCLES(PULSE_CYCLES), .W(20)) u_clr_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(config_q[`CFG_INTR_CLR_BIT]),
    .busy_q(clr_pulse_busy)
  ); // [R5] [R15]

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  wire tree_mode;
  wire tree_result;
  assign tree_mode = fan_dac_out_tree_select; // [R3]
  // Tree chain over tree inputs, high strap, intrusion line and voltage-id inputs so any one low pin flips the result
  assign tree_result = ~&{tree_inputs, addr_strap_high, intrusion_line_i,
                          cpu_voltage_id_inputs};

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_strap_low_tree_out_o <= 1'b0;
      addr_strap_low_tree_out_oe <= 1'b0;
      fan_dac_en_q <= 1'b0;
      slave_addr_q <= 7'h00;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      sda_rx_q <= 1'b1;
      intrusion_line_o <= 1'b0;
      intrusion_line_oe <= 1'b0;
      sys_rst_b_o <= 1'b0;
      sys_rst_b_oe <= 1'b0;
      int_b_q <= 1'b1;
    end else begin
      addr_strap_low_tree_out_o <= tree_result; // [R2]
      addr_strap_low_tree_out_oe <= tree_mode; // [R2]
      fan_dac_en_q <= !tree_mode; // [R3]
      // Strap not sampled while we drive it in tree mode
      if (!tree_mode && !addr_strap_low_tree_out_oe) begin
        slave_addr_q <= {addr_high_q, addr_strap_high, addr_strap_low_tree_out_i}; // [R1] [R12]
      end
      sda_o <= 1'b0;
      sda_oe <= !sda_tx; // [R4]
      sda_rx_q <= sda_i; // [R4]
      intrusion_line_o <= 1'b0;
      intrusion_line_oe <= clr_pulse_busy; // [R5]
      sys_rst_b_o <= 1'b0;
      sys_rst_b_oe <= rst_pulse_busy; // [R7]
      int_b_q <= !(config_q[`CFG_INT_EN_BIT] && |(status_d & mask_q)); // [R6] [R9]
    end
  end
endmodule

`default_nettype wire

// ==== verilog/monitor_pin_defines.vh ====
// Register offsets, field positions, reset values and timing counts for the pin controller
`ifndef MONITOR_PIN_DEFINES_VH
`define MONITOR_PIN_DEFINES_VH

`define REG_CONFIG 8'h40
`define REG_INT_STATUS 8'h41
`define REG_INT_MASK 8'h43
`define REG_INTR_CLEAR 8'h46
`define REG_VID 8'h47
`define REG_SER_ADDR 8'h48
`define REG_VID_FIFTH 8'h49
`define REG_FAN_DAC 8'h19
`define REG_OOS_EVENTS 8'h4c

`define CFG_START_BIT 0
`define CFG_INT_EN_BIT 1
`define CFG_RST_PULSE_BIT 4
`define CFG_INTR_CLR_BIT 6
`define INTR_CLEAR_BIT 7

`define CONFIG_RESET 8'h08
`define SER_ADDR_HIGH_RESET 5'h0b
`define FAN_DAC_RESET 8'hff
`define VID_UPPER_RESET 4'h5
`define VID_FIFTH_UPPER 7'h40

`define ST_OOS_BIT 0
`define ST_INTRUSION_BIT 1
`define ST_EXT_RST_BIT 2

`define CLK_HZ 40000000
`define PULSE_MIN_MS 20
`define PULSE_CYCLES ((`CLK_HZ / 1000) * `PULSE_MIN_MS)
`define DEBOUNCE_US 100
`define DEBOUNCE_CYCLES ((`CLK_HZ / 1000000) * `DEBOUNCE_US)

`endif

// ==== verilog/pulse_timer.v ====
// Minimum-width pulse timer for open-drain outputs
`default_nettype none

module pulse_timer #(
  parameter integer CYCLES = 800000,
  parameter integer W = 20
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Control
  input wire start,
  output reg busy_q
);
  reg [W-1:0] cnt_q;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= {W{1'b0}};
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q <= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1};
      busy_q <= 1'b1;
    end else if (busy_q) begin
      // Count down fully before release so width never falls short
      if (cnt_q == {W{1'b0}}) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

`default_nettype wire

// ==== test/monitor_board.sv ====
// Board model around the pin controller: pull-ups, intrusion latch, host drivers
`default_nettype none
module monitor_board (
  // Clock
  input wire logic mclk,
  // Device pin enables and host pulls
  input wire logic sda_oe,
  input wire logic host_sda_low,
  input wire logic intr_oe,
  input wire logic lid_open,
  input wire logic rst_oe,
  input wire logic host_rst_low,
  input wire logic strap_oe,
  input wire logic strap_o,
  input wire logic strap_pin,
  // Resolved lines
  output logic sda,
  output logic intr,
  output logic rst_line,
  output logic strap
);
  timeunit 1ns;
  timeprecision 100ps;
  logic latch_q = 1'b0;
  // -----------------------------
  // Wired lines
  // -----------------------------
  // Pull-ups on the data and reset lines win unless someone sinks the line
  assign sda = !(sda_oe || host_sda_low);
  assign rst_line = !(rst_oe || host_rst_low);
  assign intr = latch_q && !intr_oe;
  assign strap = strap_oe ? strap_o : strap_pin;
  // External latch only resets while the device holds it low
  always @(posedge mclk) begin
    if (intr_oe) latch_q <= 1'b0;
    else if (lid_open) latch_q <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== test/monitor_pin_control_props.sv ====
// Port-level assertions for the pin controller
`default_nettype none
`include "monitor_pin_defines.vh"
module monitor_pin_control_props #(parameter integer PULSE_CYCLES = 20) (
  // Clock, reset, register port
  input wire mclk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata_q,
  // Pins
  input wire addr_strap_low_tree_out_i,
  input wire addr_strap_high,
  input wire addr_strap_low_tree_out_oe,
  input wire fan_dac_out_tree_select,
  input wire [6:0] slave_addr_q,
  input wire sda_tx,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  input wire sda_rx_q,
  input wire intrusion_line_o,
  input wire intrusion_line_oe,
  input wire sys_rst_b_o,
  input wire sys_rst_b_oe,
  input wire int_b_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // -----------------------------
  // Pulse length counters
  // -----------------------------
  logic [31:0] rst_n_q, clr_n_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_n_q <= '0;
      clr_n_q <= '0;
    end else begin
      rst_n_q <= sys_rst_b_oe ? rst_n_q + 1 : '0;
      clr_n_q <= intrusion_line_oe ? clr_n_q + 1 : '0;
    end
  end
  sequence cfg_wr(b);
    wr_stb && addr == `REG_CONFIG && wdata[b];
  endsequence
  sequence rst_drive;
    ##2 sys_rst_b_oe;
  endsequence
  a_rst_start: assert property (cfg_wr(4) ##0 !sys_rst_b_oe |-> rst_drive)
    else $error("reset pulse did not start");
  a_rst_width: assert property ($fell(sys_rst_b_oe) |-> rst_n_q == PULSE_CYCLES)
    else $error("reset pulse width wrong");
  a_clr_width: assert property ($fell(intrusion_line_oe) |-> clr_n_q == PULSE_CYCLES)
    else $error("clear pulse width wrong");
  a_od_low: assert property (!sda_o && !(sys_rst_b_oe && sys_rst_b_o)
    && !(intrusion_line_oe && intrusion_line_o))
    else $error("open-drain pin driven high");
  a_sda_follow: assert property ($past(rst_b) |-> sda_oe == !$past(sda_tx)
    && sda_rx_q == $past(sda_i))
    else $error("data line drive or receive wrong");
  a_tree_oe: assert property ($past(rst_b) |->
    addr_strap_low_tree_out_oe == $past(fan_dac_out_tree_select))
    else $error("tree output enable wrong");
  a_strap_bits: assert property ($past(rst_b) && !addr_strap_low_tree_out_oe
    && !$past(addr_strap_low_tree_out_oe)
    && $stable({addr_strap_high, addr_strap_low_tree_out_i})
    |-> slave_addr_q[1:0] == {addr_strap_high, addr_strap_low_tree_out_i})
    else $error("strap bits not in address");
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata_q == 8'h00)
    else $error("read data outside read slot");
  a_int_off: assert property ($rose(rst_b) |-> int_b_q)
    else $error("interrupt active after reset");
endmodule
`default_nettype wire

// ==== test/monitor_pin_control_tb.sv ====
// Self-checking bench for the pin controller
`default_nettype none
`include "monitor_pin_defines.vh"
module monitor_pin_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PC = 20;
  localparam int DB = 4;
  logic mclk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, sda_tx = 1, strap_hi = 1;
  logic sel = 0, lid = 0, host_sda = 0, host_rst = 0;
  logic [7:0] addr = 0, wdata = 0, tin = 8'hff, oos = 0;
  logic [4:0] vid = 5'h16;
  int mismatches = 0, total_checks = 0, cyc = 0, n;
  wire sda, intr, rst_line, s_lo, s_o, s_oe, sd_o, sd_oe, sd_rx;
  wire i_o, i_oe, r_o, r_oe, int_b, dac_en;
  wire [7:0] rdata, dac;
  wire [6:0] saddr;
  monitor_pin_control #(.PULSE_CYCLES(PC), .DEBOUNCE_CYCLES(DB)) dut (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_q(rdata), .addr_strap_low_tree_out_i(s_lo),
    .addr_strap_low_tree_out_o(s_o), .addr_strap_low_tree_out_oe(s_oe),
    .addr_strap_high(strap_hi), .fan_dac_out_tree_select(sel), .tree_inputs(tin),
    .fan_dac_code_q(dac), .fan_dac_en_q(dac_en), .slave_addr_q(saddr), .sda_i(sda),
    .sda_tx(sda_tx), .sda_o(sd_o), .sda_oe(sd_oe), .sda_rx_q(sd_rx),
    .intrusion_line_i(intr), .intrusion_line_o(i_o), .intrusion_line_oe(i_oe),
    .sys_rst_b_i(rst_line), .sys_rst_b_o(r_o), .sys_rst_b_oe(r_oe),
    .oos_events(oos), .cpu_voltage_id_inputs(vid), .int_b_q(int_b));
  monitor_board board (.mclk(mclk), .sda_oe(sd_oe), .host_sda_low(host_sda),
    .intr_oe(i_oe), .lid_open(lid), .rst_oe(r_oe), .host_rst_low(host_rst),
    .strap_oe(s_oe), .strap_o(s_o), .strap_pin(1'b0), .sda(sda), .intr(intr),
    .rst_line(rst_line), .strap(s_lo));
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  // -----------------------------
  // Shared tasks
  // -----------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge mclk) wr_stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) {addr, rd_stb} <= {a, 1'b1};
    @(posedge mclk) rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Length in cycles of the next pulse on either open-drain pin
  task automatic pulse_len(input logic r);
    n = 0;
    while (!(r ? r_oe : i_oe) && n < 9) begin
      wait_n(1);
      n++;
    end
    n = 0;
    while ((r ? r_oe : i_oe) && n < 99) begin
      wait_n(1);
      n++;
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // -----------------------------
  // Scenarios
  // -----------------------------
  task automatic t_sda;
    @(posedge mclk) {host_sda, sda_tx} <= 2'b01;
    wait_n(2);
    chk({5'h0, sd_oe, sd_rx, sd_o}, 8'h02);
    @(posedge mclk) host_sda <= 1'b1;
    wait_n(2);
    chk({5'h0, sd_oe, sd_rx, sd_o}, 8'h00);
    @(posedge mclk) {host_sda, sda_tx} <= 2'b00;
    wait_n(2);
    chk({5'h0, sd_oe, sd_rx, sd_o}, 8'h04);
    chk({6'h0, i_o, r_o}, 8'h00);
  endtask
  task automatic t_regs;
    rdc(`REG_CONFIG, `CONFIG_RESET);
    rdc(`REG_VID, {`VID_UPPER_RESET, vid[3:0]});
    rdc(`REG_VID_FIFTH, {`VID_FIFTH_UPPER, vid[4]});
    rdc(`REG_SER_ADDR, {1'b0, `SER_ADDR_HIGH_RESET, strap_hi, 1'b0});
    rdc(8'h7f, 8'h00);
    rdc(`REG_FAN_DAC, `FAN_DAC_RESET);
    wr(`REG_FAN_DAC, 8'h5a);
    rdc(`REG_FAN_DAC, 8'h5a);
    chk(dac, 8'h5a);
    wr(`REG_SER_ADDR, 8'hfc);
    rdc(`REG_SER_ADDR, {1'b0, 5'h1f, strap_hi, 1'b0});
    chk({1'b0, saddr}, {1'b0, 5'h1f, strap_hi, 1'b0});
  endtask
  task automatic t_irq;
    wr(`REG_INT_MASK, 8'h03);
    @(posedge mclk) oos <= 8'h01;
    wait_n(3);
    chk(8'(int_b), 8'h01);
    rdc(`REG_OOS_EVENTS, 8'h01);
    rdc(`REG_INTR_CLEAR, 8'h00);
    wr(`REG_CONFIG, 8'h0a);
    wait_n(2);
    chk(8'(int_b), 8'h00);
    rdc(`REG_INT_STATUS, 8'h01);
    wr(`REG_INT_MASK, 8'h02);
    wait_n(2);
    chk(8'(int_b), 8'h01);
    @(posedge mclk) lid <= 1'b1;
    wait_n(4);
    chk(8'(int_b), 8'h00);
    wr(`REG_INTR_CLEAR, 8'h80);
    wr(`REG_INT_STATUS, 8'h01);
    rdc(`REG_INT_STATUS, 8'h00);
    chk(8'(int_b), 8'h01);
  endtask
  task automatic t_tree;
    @(posedge mclk) {sel, vid} <= {1'b1, 5'h1f};
    wait_n(2);
    chk({6'h0, s_oe, dac_en}, 8'h02);
    chk(8'(s_lo), 8'h00);
    @(posedge mclk) tin <= 8'hfe;
    wait_n(2);
    chk(8'(s_lo), 8'h01);
    @(posedge mclk) {sel, vid, tin, lid} <= {1'b1, 5'h16, 8'hff, 1'b0};
    @(posedge mclk) sel <= 1'b0;
    wait_n(2);
    chk({6'h0, s_oe, dac_en}, 8'h01);
  endtask
  task automatic t_pulses;
    wr(`REG_CONFIG, 8'h4a);
    pulse_len(1'b0);
    chk(8'(n), 8'(PC));
    chk(8'(intr), 8'h00);
    rdc(`REG_INT_STATUS, 8'h00);
    wr(`REG_CONFIG, 8'h1a);
    pulse_len(1'b1);
    chk(8'(n), 8'(PC));
    rdc(`REG_CONFIG, 8'h0a);
  endtask
  task automatic t_soft;
    @(posedge mclk) host_rst <= 1'b1;
    wait_n(DB + 3);
    @(posedge mclk) host_rst <= 1'b0;
    wait_n(2);
    rdc(`REG_CONFIG, `CONFIG_RESET);
    rdc(`REG_INT_STATUS, 8'h04);
    rdc(`REG_SER_ADDR, {1'b0, `SER_ADDR_HIGH_RESET, strap_hi, 1'b0});
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_sda;
    t_regs;
    t_irq;
    t_tree;
    t_pulses;
    t_soft;
    wrap_up;
  end
endmodule
bind monitor_pin_control monitor_pin_control_props #(.PULSE_CYCLES(PULSE_CYCLES)) props (
  .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata_q(rdata_q), .addr_strap_high(addr_strap_high),
  .addr_strap_low_tree_out_i(addr_strap_low_tree_out_i),
  .addr_strap_low_tree_out_oe(addr_strap_low_tree_out_oe),
  .fan_dac_out_tree_select(fan_dac_out_tree_select), .slave_addr_q(slave_addr_q),
  .sda_tx(sda_tx), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .sda_rx_q(sda_rx_q),
  .intrusion_line_o(intrusion_line_o), .intrusion_line_oe(intrusion_line_oe),
  .sys_rst_b_o(sys_rst_b_o), .sys_rst_b_oe(sys_rst_b_oe), .int_b_q(int_b_q));
`default_nettype wire
